/* File: pkg/mmwd_pkg.sv */
// Constants, register map and state encoding for the memory map and wait-state decoder
`default_nettype none
package mmwd_pkg;
  // Register offsets on the register port
  localparam logic [15:0] MMWD_OFF_PAGE_EXT = 16'h001E;
  localparam logic [15:0] MMWD_OFF_WS_RANGES = 16'h0028;
  localparam logic [15:0] MMWD_OFF_WS_CTRL = 16'h002B;
  localparam logic [15:0] MMWD_OFF_MODE_STATUS = 16'h0030;
  // Reset values
  localparam logic [3:0] MMWD_RST_PAGE_EXT = 4'h0;
  localparam logic [15:0] MMWD_RST_WS_RANGES = 16'h7FFF;
  localparam logic MMWD_RST_DOUBLER = 1'b0;
  localparam logic [8:0] MMWD_RST_VPP = 9'h1FF;
  localparam logic MMWD_RST_OVERLAY = 1'b0;
  // Wait-state range fields
  localparam int MMWD_F_XPA = 15;
  localparam int MMWD_F_IO = 12;
  localparam int MMWD_F_DATA_HI = 9;
  localparam int MMWD_F_DATA_LO = 6;
  localparam int MMWD_F_PROG_HI = 3;
  localparam int MMWD_F_PROG = 0;
  localparam int MMWD_F_WS_COUNT_BITS = 14;
  localparam int MMWD_F_DOUBLER = 0;
  // Mode/status fields
  localparam int MMWD_F_VPP = 7;
  localparam int MMWD_F_ROM_EN = 6;
  localparam int MMWD_F_OVERLAY = 5;
  // Address map
  localparam logic [19:0] MMWD_RESET_VECTOR = 20'h0FF80;
  localparam logic [15:0] MMWD_TEST_LO = 16'hFF00;
  localparam logic [15:0] MMWD_TEST_HI = 16'hFF7F;
  localparam logic [15:0] MMWD_RAM_LO = 16'h0060;
  localparam logic [15:0] MMWD_RAM_HI = 16'h3FFF;
  localparam int MMWD_RAM_BLOCK_BIT = 13;
  // Cycle counts
  localparam logic [1:0] MMWD_BOOT_SETTLE = 2'h3;
  localparam logic [3:0] MMWD_WS_MAX = 4'hE;
  // Access spaces
  localparam logic [1:0] MMWD_SP_PROG = 2'h0;
  localparam logic [1:0] MMWD_SP_DATA = 2'h1;
  localparam logic [1:0] MMWD_SP_IO = 2'h2;
  // Far operation kinds
  localparam logic [2:0] MMWD_FAR_JMP_IMM = 3'h0;
  localparam logic [2:0] MMWD_FAR_JMP_ACC = 3'h1;
  localparam logic [2:0] MMWD_FAR_CALL_IMM = 3'h2;
  localparam logic [2:0] MMWD_FAR_CALL_ACC = 3'h3;
  localparam logic [2:0] MMWD_FAR_RET = 3'h4;
  localparam logic [2:0] MMWD_FAR_RET_IRQ = 3'h5;
  typedef enum logic [1:0] {
    MMWD_IDLE = 2'b01,
    MMWD_WAIT = 2'b10
  } mmwd_state_t;
endpackage
`default_nettype wire

/* File: logic/mmwd_decoder.sv */
// Memory map decoder, program page extension, vector former and wait-state generator
//
// Overview of operation
// - Boot pin low at reset: start at FF80h with on-chip ROM enabled.
// - A 4K-word program ROM occupies the top of program page zero.
// - ROM words FF00h-FF7Fh are held back for factory test.
// - Dual-access RAM is two independent 8K-word blocks.
// - RAM decodes at data 0060h-3FFFh, and in program space when overlay set.
// - Reset, interrupt and trap load the PC; each vector slot is four words.
// - Vector addresses come from the vector page pointer, 128-word pages.
// - Hardware reset sets the vector page pointer to all ones.
// - Twenty program address lines reach 1024K words.
// - Page extension register sits at 001Eh and resets to zero.
// - Far jumps and calls load the page from the target; far returns restore it.
// - Accumulator far forms take the target from accumulator bits 19..0.
// - Table read and write use a 20-bit accumulator program address.
// - Everything else except a register write to 001Eh leaves the page extension register unchanged.
// - Program space is 16 pages of 64K words picked by the page register.
// - Overlay clear: low 16K of every page, page 0 included, external; set: RAM in every page.
// - External cycles get at most fourteen generated wait states; ready held low stretches them further.
// - Range bits 13..0 at zero turn off the generator clock; I/O count bit 14 is not looked at.
// - Low 15 range bits hold five 3-bit counts for five ranges.
// - Doubler bit scales every count by one or two.
// - After reset every external access gets seven wait states.
// - Range register layout: EXTENDED_PROGRAM_RANGE_BIT, I/O, data high/low, program high/low.
// - EXTENDED_PROGRAM_RANGE_BIT set: low field covers all program space; clear: split at x8000h.
// - Doubler is bit 0 of the control register at 002Bh, reset zero.
`default_nettype none
module mmwd_decoder #(
  parameter int ROM_WORDS = 4096
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic boot_mode_select_pin,
  input wire logic ext_ready_pin,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic acc_valid,
  input wire logic [1:0] acc_space,
  input wire logic [15:0] acc_addr,
  input wire logic acc_table,
  input wire logic acc_write,
  input wire logic [19:0] acc_value,
  output logic acc_busy,
  output logic acc_done,
  output logic sel_rom,
  output logic sel_ram,
  output logic ram_block,
  output logic rom_test_area,
  output logic [15:0] mem_index,
  output logic ext_cycle,
  output logic [19:0] ext_addr,
  output logic [1:0] ext_space,
  output logic ext_write,
  output logic ws_clock_on,
  input wire logic vector_req,
  input wire logic [4:0] vector_num,
  input wire logic far_valid,
  input wire logic [2:0] far_kind,
  input wire logic [19:0] far_target,
  input wire logic [3:0] far_ret_page,
  output logic [3:0] current_page,
  output logic pc_load,
  output logic [19:0] pc_load_addr
);
  if (ROM_WORDS < 1024 || ROM_WORDS > 4096 || (ROM_WORDS & (ROM_WORDS - 1)) != 0) begin : g_bad
    $error("ROM_WORDS must be a power of two from 1024 to 4096");
  end
  localparam logic [16:0] ROM_BASE17 = 17'h10000 - 17'(ROM_WORDS);
  localparam logic [15:0] ROM_BASE = ROM_BASE17[15:0];

  logic [2:0] mode_sync_q;
  logic [2:0] rdy_sync_q;
  logic mode_lvl_q;
  logic rdy_lvl_q;
  logic [1:0] boot_cnt_q;
  logic boot_pend_q;
  logic rom_en_q;
  logic [3:0] page_q;
  logic [15:0] ranges_q;
  logic doubler_q;
  logic [8:0] vpp_q;
  logic overlay_q;
  logic [15:0] rdata_q;
  mmwd_pkg::mmwd_state_t st_q;
  logic [3:0] cnt_q;
  logic done_q;
  logic sel_rom_q;
  logic sel_ram_q;
  logic ram_block_q;
  logic test_q;
  logic [15:0] index_q;
  logic [19:0] ext_addr_q;
  logic [1:0] ext_space_q;
  logic ext_write_q;
  logic pc_load_q;
  logic [19:0] pc_addr_q;
  logic boot_fire;
  logic vec_fire;
  logic far_fire;
  logic acc_take;
  logic page_wr;
  logic dec_rom;
  logic dec_ram;
  logic dec_ext;
  logic [19:0] dec_pa;
  logic [15:0] dec_off;
  logic [2:0] dec_base;
  logic [3:0] ws_cnt_d;

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdy_sync_q <= 3'h0;
      rdy_lvl_q <= 1'b0;
    end else begin
      rdy_sync_q <= {rdy_sync_q[1:0], ext_ready_pin};
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
        rdy_lvl_q <= rdy_sync_q[2];
      end
    end
  end

  // Boot pin keeps sampling through reset, so its level has settled when boot is caught
  always_ff @(posedge clk) begin
    mode_sync_q <= {mode_sync_q[1:0], boot_mode_select_pin};
    if (mode_sync_q[1] == mode_sync_q[2]) begin
      mode_lvl_q <= mode_sync_q[2];
    end
  end

  // Boot pin is caught once the synchroniser has settled after release
  assign boot_fire = boot_pend_q && (boot_cnt_q == mmwd_pkg::MMWD_BOOT_SETTLE);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      boot_pend_q <= 1'b1;
      boot_cnt_q <= 2'h0;
      rom_en_q <= 1'b0;
    end else if (boot_pend_q) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      if (boot_fire) begin
        boot_pend_q <= 1'b0;
        rom_en_q <= ~mode_lvl_q;
      end
    end
  end

  assign vec_fire = vector_req && !boot_pend_q;
  assign far_fire = far_valid && !boot_pend_q && !vector_req;
  assign page_wr = reg_wr && (reg_addr == mmwd_pkg::MMWD_OFF_PAGE_EXT);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_load_q <= 1'b0;
      pc_addr_q <= 20'h00000;
    end else begin
      pc_load_q <= boot_fire || vec_fire || far_fire;
      if (boot_fire) begin
        pc_addr_q <= mmwd_pkg::MMWD_RESET_VECTOR;
      end else if (vec_fire) begin
        pc_addr_q <= {page_q, vpp_q, vector_num, 2'h0};
      end else if (far_fire) begin
        if (far_kind == mmwd_pkg::MMWD_FAR_JMP_ACC || far_kind == mmwd_pkg::MMWD_FAR_CALL_ACC) begin
          pc_addr_q <= acc_value;
        end else begin
          pc_addr_q <= far_target;
        end
      end
    end
  end

  // far operations own the page; a far op beats a same-cycle write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      page_q <= mmwd_pkg::MMWD_RST_PAGE_EXT;
    end else if (far_fire) begin
      if (far_kind == mmwd_pkg::MMWD_FAR_RET || far_kind == mmwd_pkg::MMWD_FAR_RET_IRQ) begin
        page_q <= far_ret_page;
      end else if (far_kind == mmwd_pkg::MMWD_FAR_JMP_ACC
                   || far_kind == mmwd_pkg::MMWD_FAR_CALL_ACC) begin
        page_q <= acc_value[19:16];
      end else begin
        page_q <= far_target[19:16];
      end
    end else if (page_wr) begin
      page_q <= reg_wdata[3:0];
    end
  end

  // Wait-state and mode registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ranges_q <= mmwd_pkg::MMWD_RST_WS_RANGES;
      doubler_q <= mmwd_pkg::MMWD_RST_DOUBLER;
      vpp_q <= mmwd_pkg::MMWD_RST_VPP;
      overlay_q <= mmwd_pkg::MMWD_RST_OVERLAY;
    end else if (reg_wr) begin
      if (reg_addr == mmwd_pkg::MMWD_OFF_WS_RANGES) begin
        ranges_q <= reg_wdata;
      end else if (reg_addr == mmwd_pkg::MMWD_OFF_WS_CTRL) begin
        doubler_q <= reg_wdata[mmwd_pkg::MMWD_F_DOUBLER];
      end else if (reg_addr == mmwd_pkg::MMWD_OFF_MODE_STATUS) begin
        vpp_q <= reg_wdata[mmwd_pkg::MMWD_F_VPP +: 9];
        overlay_q <= reg_wdata[mmwd_pkg::MMWD_F_OVERLAY];
      end
    end
  end

  // Read data stand for one cycle only; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else if (!reg_rd) begin
      rdata_q <= 16'h0000;
    end else if (reg_addr == mmwd_pkg::MMWD_OFF_PAGE_EXT) begin
      rdata_q <= {12'h000, page_q};
    end else if (reg_addr == mmwd_pkg::MMWD_OFF_WS_RANGES) begin
      rdata_q <= ranges_q;
    end else if (reg_addr == mmwd_pkg::MMWD_OFF_WS_CTRL) begin
      rdata_q <= {15'h0000, doubler_q};
    end else if (reg_addr == mmwd_pkg::MMWD_OFF_MODE_STATUS) begin
      rdata_q <= {vpp_q, rom_en_q, overlay_q, 5'h00};
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Address decode of the pending access
  always_comb begin
    // table ops use the accumulator address
    if (acc_space == mmwd_pkg::MMWD_SP_PROG && acc_table) begin
      dec_pa = acc_value;
    end else if (acc_space == mmwd_pkg::MMWD_SP_PROG) begin
      dec_pa = {page_q, acc_addr};
    end else begin
      dec_pa = {4'h0, acc_addr};
    end
    dec_off = dec_pa[15:0];
    dec_rom = 1'b0;
    dec_ram = 1'b0;
    dec_ext = 1'b0;
    dec_base = ranges_q[mmwd_pkg::MMWD_F_IO +: 3];
    if (acc_space == mmwd_pkg::MMWD_SP_PROG) begin
      // overlay puts RAM low in every page
      if (overlay_q && dec_off <= mmwd_pkg::MMWD_RAM_HI) begin
        dec_ram = 1'b1;
      // ROM at the top of page zero
      end else if (rom_en_q && dec_pa[19:16] == 4'h0 && dec_off >= ROM_BASE) begin
        dec_rom = 1'b1;
      end else begin
        dec_ext = 1'b1;
      end
      if (!ranges_q[mmwd_pkg::MMWD_F_XPA] && dec_off[15]) begin
        dec_base = ranges_q[mmwd_pkg::MMWD_F_PROG_HI +: 3];
      end else begin
        dec_base = ranges_q[mmwd_pkg::MMWD_F_PROG +: 3];
      end
    end else if (acc_space == mmwd_pkg::MMWD_SP_DATA) begin
      if (dec_off >= mmwd_pkg::MMWD_RAM_LO && dec_off <= mmwd_pkg::MMWD_RAM_HI) begin
        dec_ram = 1'b1;
      end else if (dec_off[15:14] != 2'h0) begin
        dec_ext = 1'b1;
      end
      if (dec_off[15]) begin
        dec_base = ranges_q[mmwd_pkg::MMWD_F_DATA_HI +: 3];
      end else begin
        dec_base = ranges_q[mmwd_pkg::MMWD_F_DATA_LO +: 3];
      end
    end else begin
      dec_ext = 1'b1;
    end
  end

  assign ws_cnt_d = doubler_q ? {dec_base, 1'b0} : {1'b0, dec_base};
  assign acc_take = acc_valid && (st_q == mmwd_pkg::MMWD_IDLE) && !boot_pend_q;

  // accesses outside ROM, RAM and data 0000h-005Fh run on the external bus
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= mmwd_pkg::MMWD_IDLE;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      case (st_q)
        mmwd_pkg::MMWD_IDLE: begin
          done_q <= acc_take && !dec_ext;
          if (acc_take && dec_ext) begin
            st_q <= mmwd_pkg::MMWD_WAIT;
            cnt_q <= ws_cnt_d;
          end
        end
        mmwd_pkg::MMWD_WAIT: begin
          done_q <= (cnt_q == 4'h0) && rdy_lvl_q;
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (rdy_lvl_q) begin
            st_q <= mmwd_pkg::MMWD_IDLE;
          end
        end
        default: begin
          st_q <= mmwd_pkg::MMWD_IDLE;
          done_q <= 1'b0;
        end
      endcase
    end
  end

  // Targets are held until the next access is taken
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_rom_q <= 1'b0;
      sel_ram_q <= 1'b0;
      ram_block_q <= 1'b0;
      test_q <= 1'b0;
      index_q <= 16'h0000;
      ext_addr_q <= 20'h00000;
      ext_space_q <= mmwd_pkg::MMWD_SP_PROG;
      ext_write_q <= 1'b0;
    end else if (acc_take) begin
      sel_rom_q <= dec_rom;
      sel_ram_q <= dec_ram;
      // block pick by address bit 13
      ram_block_q <= dec_ram && dec_off[mmwd_pkg::MMWD_RAM_BLOCK_BIT];
      test_q <= dec_rom && dec_off >= mmwd_pkg::MMWD_TEST_LO
                && dec_off <= mmwd_pkg::MMWD_TEST_HI;
      index_q <= dec_rom ? (dec_off - ROM_BASE) : dec_off;
      ext_addr_q <= dec_pa;
      ext_space_q <= acc_space;
      ext_write_q <= acc_write && !dec_rom;
    end
  end

  // generator clock off when range bits 13..0 are zero; I/O field bit 14 is not looked at
  assign ws_clock_on = |ranges_q[mmwd_pkg::MMWD_F_WS_COUNT_BITS-1:0];

  assign reg_rdata = rdata_q;
  assign acc_busy = (st_q != mmwd_pkg::MMWD_IDLE) || boot_pend_q;
  assign acc_done = done_q;
  assign sel_rom = sel_rom_q;
  assign sel_ram = sel_ram_q;
  assign ram_block = ram_block_q;
  assign rom_test_area = test_q;
  assign mem_index = index_q;
  assign ext_cycle = st_q[1];
  assign ext_addr = ext_addr_q;
  assign ext_space = ext_space_q;
  assign ext_write = ext_write_q;
  assign current_page = page_q;
  assign pc_load = pc_load_q;
  assign pc_load_addr = pc_addr_q;

  sequence s_ext_start;
    acc_take && dec_ext;
  endsequence
  sequence s_far_imm;
    far_fire && far_kind == mmwd_pkg::MMWD_FAR_JMP_IMM;
  endsequence

  a_reset_values: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> page_q == 4'h0 && vpp_q == 9'h1FF && ranges_q == 16'h7FFF)
    else $error("reset values wrong");
  a_boot_vector: assert property (@(posedge clk) disable iff (!reset_n)
    boot_fire |=> pc_load_q && pc_addr_q == 20'h0FF80 && rom_en_q == !$past(mode_lvl_q))
    else $error("boot vector or ROM enable wrong");
  a_vector_slot: assert property (@(posedge clk) disable iff (!reset_n)
    vec_fire |=> pc_load_q && pc_addr_q[1:0] == 2'h0
      && pc_addr_q[15:7] == $past(vpp_q) && pc_addr_q[6:2] == $past(vector_num))
    else $error("vector address wrong");
  a_far_page: assert property (@(posedge clk) disable iff (!reset_n)
    s_far_imm |=> page_q == $past(far_target[19:16]) && pc_addr_q == $past(far_target))
    else $error("far jump page wrong");
  a_acc_target: assert property (@(posedge clk) disable iff (!reset_n)
    far_fire && far_kind == mmwd_pkg::MMWD_FAR_CALL_ACC |=> pc_addr_q == $past(acc_value))
    else $error("accumulator target wrong");
  a_page_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !far_fire && !page_wr |=> $stable(page_q))
    else $error("page changed without cause");
  a_ws_load: assert property (@(posedge clk) disable iff (!reset_n)
    s_ext_start |=> st_q == mmwd_pkg::MMWD_WAIT && cnt_q == $past(ws_cnt_d)
      && cnt_q <= mmwd_pkg::MMWD_WS_MAX)
    else $error("wait count load wrong");
  a_ws_count: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == mmwd_pkg::MMWD_WAIT && cnt_q != 4'h0 |=> cnt_q == $past(cnt_q) - 4'h1 && !done_q)
    else $error("wait count step wrong");
  a_ram_window: assert property (@(posedge clk) disable iff (!reset_n)
    acc_take && acc_space == mmwd_pkg::MMWD_SP_DATA && acc_addr[15:14] == 2'h0
      && acc_addr >= 16'h0060 |=> sel_ram_q && ram_block_q == $past(acc_addr[13]))
    else $error("RAM window decode wrong");
  a_gate_off: assert property (@(posedge clk) disable iff (!reset_n)
    ranges_q[13:0] == 14'h0000 |-> !ws_clock_on)
    else $error("generator clock left on");
endmodule
`default_nettype wire

/* File: tb/mmwd_ext_mem.sv */
// External memory model: answers external cycles, optionally holding ready low
`default_nettype none
module mmwd_ext_mem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ext_cycle,
  input wire logic [7:0] stall_cycles,
  output logic ext_ready_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic cyc_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= ext_cycle;
      if (ext_cycle && !cyc_q) begin
        cnt_q <= stall_cycles;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // Ready drops in the first wait cycle; the decoder sees it only a few cycles later
  assign ext_ready_pin = (cnt_q == 8'h00) && !(ext_cycle && !cyc_q && stall_cycles != 8'h00);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the memory map and wait-state decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, rdy, reg_wr = 1'b0, reg_rd = 1'b0, boot_pin = 1'b0;
  logic ext_seen;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, acc_addr = 16'h0000;
  logic acc_valid = 1'b0, acc_table = 1'b0, acc_write = 1'b0, acc_busy, acc_done;
  logic [1:0] acc_space = 2'h0, ext_space;
  logic [19:0] acc_value = 20'h00000, ext_addr, far_target = 20'h00000, pc_load_addr;
  logic sel_rom, sel_ram, ram_block, rom_test_area, ext_cycle, ext_write, ws_clock_on;
  logic [15:0] mem_index;
  logic vector_req = 1'b0, far_valid = 1'b0, pc_load;
  logic [4:0] vector_num = 5'h00;
  logic [2:0] far_kind = 3'h0;
  logic [3:0] far_ret_page = 4'h0, current_page;
  logic [7:0] stall = 8'h00;
  int err_total = 0, checks_done = 0, k;
  logic [15:0] rv;
  initial begin
    forever #2.5 clk = ~clk;
  end
  mmwd_decoder dut_u (.clk(clk), .reset_n(reset_n), .boot_mode_select_pin(boot_pin),
    .ext_ready_pin(rdy), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_space(acc_space),
    .acc_addr(acc_addr), .acc_table(acc_table), .acc_write(acc_write), .acc_value(acc_value),
    .acc_busy(acc_busy), .acc_done(acc_done), .sel_rom(sel_rom), .sel_ram(sel_ram),
    .ram_block(ram_block), .rom_test_area(rom_test_area), .mem_index(mem_index),
    .ext_cycle(ext_cycle), .ext_addr(ext_addr), .ext_space(ext_space), .ext_write(ext_write),
    .ws_clock_on(ws_clock_on), .vector_req(vector_req), .vector_num(vector_num),
    .far_valid(far_valid), .far_kind(far_kind), .far_target(far_target),
    .far_ret_page(far_ret_page), .current_page(current_page), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr));
  mmwd_ext_mem mem_u (.clk(clk), .reset_n(reset_n), .ext_cycle(ext_cycle),
    .stall_cycles(stall), .ext_ready_pin(rdy));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Returns edges from the take edge to the cycle where done shows
  task automatic acc(input logic [1:0] s, input logic [15:0] a, input logic t,
                     input logic [19:0] v, output int n);
    @(posedge clk);
    acc_space <= s;
    acc_addr <= a;
    acc_table <= t;
    acc_value <= v;
    acc_valid <= 1'b1;
    @(posedge clk);
    acc_valid <= 1'b0;
    n = 1;
    #1;
    ext_seen = ext_cycle;
    while (acc_done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic t_reset();
    rd(16'h0028, rv); chk(20'(rv), 20'h07FFF);
    rd(16'h001E, rv); chk(20'(rv), 20'h00000);
    rd(16'h002B, rv); chk(20'(rv), 20'h00000);
    rd(16'h0030, rv); chk(20'(rv), 20'h0FFC0);
    rd(16'h0044, rv); chk(20'(rv), 20'h00000);
    wr(16'h001E, 16'hFFF1); rd(16'h001E, rv); chk(20'(rv), 20'h00001);
    wr(16'h002B, 16'hFFFE); rd(16'h002B, rv); chk(20'(rv), 20'h00000);
    $display("test reset_regs done");
  endtask
  task automatic t_waits();
    logic [1:0] sp [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
    logic [15:0] ad [5] = '{16'h1000, 16'h9000, 16'h5000, 16'h9000, 16'h0010};
    acc(2'h2, 16'h0010, 1'b0, 20'h0, k); chk(20'(k), 20'd9);
    chk({19'h0, ext_seen}, 20'h1);
    wr(16'h0028, 16'h58D1);
    for (int d = 0; d < 2; d++) begin
      wr(16'h002B, 16'(d));
      for (int i = 0; i < 5; i++) begin
        acc(sp[i], ad[i], 1'b0, 20'h0, k);
        chk(20'(k), 20'((i + 1) * (d + 1) + 2));
        chk(20'(ext_space), 20'(sp[i]));
        chk(ext_addr, {(i < 2) ? 4'h1 : 4'h0, ad[i]});
      end
    end
    wr(16'h002B, 16'h0000); wr(16'h0028, 16'hD8D1);
    acc(2'h0, 16'h9000, 1'b0, 20'h0, k); chk(20'(k), 20'd3);
    wr(16'h0028, 16'h7000); wr(16'h002B, 16'h0001);
    acc(2'h2, 16'h0000, 1'b0, 20'h0, k); chk(20'(k), 20'd16);
    chk(20'(ws_clock_on), 20'h1);
    stall <= 8'd20;
    acc(2'h2, 16'h0000, 1'b0, 20'h0, k); chk(20'(k > 20 && k < 30), 20'h1);
    stall <= 8'd0;
    wr(16'h002B, 16'h0000); wr(16'h0028, 16'h0000);
    #1 chk(20'(ws_clock_on), 20'h0);
    acc(2'h2, 16'h0000, 1'b0, 20'h0, k); chk(20'(k), 20'd2);
    $display("test wait_states done");
  endtask
  task automatic t_map();
    wr(16'h001E, 16'h0000);
    acc(2'h1, 16'h0060, 1'b0, 20'h0, k); chk({19'h0, sel_ram}, 20'h1); chk(20'(k), 20'd1);
    chk({19'h0, ext_seen}, 20'h0);
    acc(2'h1, 16'h2000, 1'b0, 20'h0, k); chk({19'h0, ram_block}, 20'h1);
    acc(2'h1, 16'h005F, 1'b0, 20'h0, k); chk({19'h0, sel_ram}, 20'h0);
    acc(2'h0, 16'hFF00, 1'b0, 20'h0, k); chk({18'h0, sel_rom, rom_test_area}, 20'h3);
    chk(20'(mem_index), 20'h00F00);
    acc(2'h0, 16'hFF80, 1'b0, 20'h0, k); chk({19'h0, rom_test_area}, 20'h0);
    wr(16'h0030, 16'hFFA0); wr(16'h001E, 16'h0002);
    acc(2'h0, 16'h0100, 1'b0, 20'h0, k); chk({19'h0, sel_ram}, 20'h1);
    wr(16'h0030, 16'hFF80);
    acc(2'h0, 16'h0100, 1'b0, 20'h0, k); chk({19'h0, sel_ram}, 20'h0);
    chk(ext_addr, 20'h20100); chk(20'(k), 20'd2);
    acc_write <= 1'b1;
    acc(2'h0, 16'h0000, 1'b1, 20'h79000, k); chk(ext_addr, 20'h79000);
    chk({19'h0, ext_write}, 20'h1);
    acc_write <= 1'b0;
    chk(20'(current_page), 20'h2);
    $display("test memory_map done");
  endtask
  task automatic t_far();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      far_kind <= 3'(i);
      far_target <= (i == 1 || i == 3) ? 20'hEEEEE : 20'h31234 + 20'(i * 20'h10000);
      acc_value <= (i == 1 || i == 3) ? 20'h31234 + 20'(i * 20'h10000) : 20'hEEEEE;
      far_ret_page <= 4'hA;
      far_valid <= 1'b1;
      @(posedge clk);
      far_valid <= 1'b0;
      #1 chk({19'h0, pc_load}, 20'h1);
      if (i < 4) begin
        chk(pc_load_addr, 20'h31234 + 20'(i * 20'h10000));
        chk(20'(current_page), 20'(3 + i));
      end else begin
        chk(20'(current_page), 20'hA);
      end
    end
    wr(16'h0030, 16'h0500); rd(16'h0030, rv); chk(20'(rv), 20'h00540);
    @(posedge clk);
    vector_num <= 5'h03;
    vector_req <= 1'b1;
    @(posedge clk);
    vector_req <= 1'b0;
    #1 chk(pc_load_addr, {4'hA, 9'h00A, 5'h03, 2'b00});
    chk(20'(current_page), 20'hA);
    $display("test far_and_vector done");
  endtask
  // Reset with the boot pin at the given level, then wait for the boot vector
  task automatic reset_and_boot(input logic pin);
    @(posedge clk);
    boot_pin <= pin;
    reset_n <= 1'b0;
    repeat (19) @(posedge clk);
    reset_n <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (pc_load !== 1'b1 && k < 12);
    chk(20'(k), 20'd4);
    chk(pc_load_addr, 20'h0FF80);
    chk(20'(current_page), 20'h0);
    chk({19'h0, acc_busy}, 20'h0);
  endtask
  task automatic t_boot_pin();
    reset_and_boot(1'b1);
    rd(16'h0030, rv); chk(20'(rv), 20'h0FF80);
    acc(2'h0, 16'hFF80, 1'b0, 20'h0, k); chk({19'h0, sel_rom}, 20'h0);
    chk(20'(k), 20'd9);
    chk({19'h0, ext_seen}, 20'h1);
    $display("test boot_pin done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    reset_and_boot(1'b0);
    t_reset();
    t_waits();
    t_map();
    t_far();
    t_boot_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire
